// >>> trsac_map.svh
// Named constants for the tape reader step and alarm control.
// Assumes it is included by bare name before any use.
`ifndef TRSAC_MAP_SVH
`define TRSAC_MAP_SVH

// Number of synchronised inputs and their reset image.
`define TRSAC_NUM_IN 14
`define TRSAC_IN_RST 14'h0000

// Number of panel switches with two contacts.
`define TRSAC_NUM_SW 3
`define TRSAC_SW_RST 3'h0

// Positions of the panel switches in the debounce vectors.
`define TRSAC_SW_STOP 0
`define TRSAC_SW_STEP 1
`define TRSAC_SW_SREAD 2

// Reset value of single control flops.
`define TRSAC_BIT_RST 1'b0

// Reset image of the registered output bundle.
`define TRSAC_OUT_RST 10'h000

`endif

// >>> trsac_pkg.sv
// Types shared by the tape reader step and alarm control.
// Assumes trsac_map.svh gives the widths used here.
`include "trsac_map.svh"

package trsac_pkg;

    // Synchronised inputs, first field is the most significant bit.
    typedef struct packed {
        logic on_line;
        logic hdr_done;
        logic seq_step;
        logic verify_err;
        logic feed_err;
        logic stop_sw_stop;
        logic stop_sw_normal;
        logic step_sw_press;
        logic step_sw_rest;
        logic sread_sw_press;
        logic sread_sw_rest;
        logic hdr_del_sw;
        logic ver_rst_sw;
        logic feed_rst_sw;
    } trsac_in_t;

    // Registered outputs toward panel, driver and sequence control.
    typedef struct packed {
        logic reader_stop;
        logic stop_lamp;
        logic step_read_pulse;
        logic reader_step;
        logic verify_restart;
        logic ver_lamp;
        logic feed_lamp;
        logic alarm;
        logic online_lamp;
        logic hdr_del_mode;
    } trsac_out_t;

    // Tracks a stop, a manual step and the later restart.
    typedef enum logic [1:0] {
        TRSAC_RUN = 2'b00,
        TRSAC_HELD = 2'b01,
        TRSAC_STEPPED = 2'b10
    } trsac_restart_t;

endpackage

// >>> trsac_top.sv
// Reader control: header delete, stop, step, step-read and alarm latches.
// Assumes all inputs are levels asynchronous to MCLK at 10 MHz.
`timescale 1ns/100ps
`include "trsac_map.svh"

module trsac_top (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic ON_LINE,
    input wire logic HDR_DONE,
    input wire logic SEQ_STEP,
    input wire logic VERIFY_ERR,
    input wire logic FEED_ERR,
    input wire logic STOP_SW_STOP,
    input wire logic STOP_SW_NORMAL,
    input wire logic STEP_SW_PRESS,
    input wire logic STEP_SW_REST,
    input wire logic SREAD_SW_PRESS,
    input wire logic SREAD_SW_REST,
    input wire logic HDR_DEL_SW,
    input wire logic VER_RST_SW,
    input wire logic FEED_RST_SW,
    output logic READER_STOP,
    output logic STOP_LAMP,
    output logic STEP_READ_PULSE,
    output logic READER_STEP,
    output logic VERIFY_RESTART,
    output logic VER_LAMP,
    output logic FEED_LAMP,
    output logic ALARM,
    output logic ONLINE_LAMP,
    output logic HDR_DEL_MODE
);

    // ------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------

    logic [`TRSAC_NUM_IN-1:0] raw_in;
    logic [`TRSAC_NUM_IN-1:0] meta_reg;
    logic [`TRSAC_NUM_IN-1:0] sync_reg;
    logic [`TRSAC_NUM_IN-1:0] prev_reg;
    trsac_pkg::trsac_in_t lvl;
    trsac_pkg::trsac_in_t rise;
    trsac_pkg::trsac_in_t fall;

    assign raw_in = {ON_LINE, HDR_DONE, SEQ_STEP, VERIFY_ERR, FEED_ERR,
                     STOP_SW_STOP, STOP_SW_NORMAL, STEP_SW_PRESS,
                     STEP_SW_REST, SREAD_SW_PRESS, SREAD_SW_REST,
                     HDR_DEL_SW, VER_RST_SW, FEED_RST_SW};

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            meta_reg <= `TRSAC_IN_RST;
            sync_reg <= `TRSAC_IN_RST;
            prev_reg <= `TRSAC_IN_RST;
        end else begin
            meta_reg <= raw_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign lvl = trsac_pkg::trsac_in_t'(sync_reg);
    assign rise = trsac_pkg::trsac_in_t'(sync_reg & ~prev_reg);
    assign fall = trsac_pkg::trsac_in_t'(~sync_reg & prev_reg);

    // ------------------------------------------------------------
    // Switch debounce latches
    // ------------------------------------------------------------

    // The make contact sets the latch and the break contact clears it,
    // so bounce on one contact alone cannot toggle the latch.
    logic [`TRSAC_NUM_SW-1:0] sw_set;
    logic [`TRSAC_NUM_SW-1:0] sw_clr;
    logic [`TRSAC_NUM_SW-1:0] sw_reg;
    logic [`TRSAC_NUM_SW-1:0] sw_d_reg;
    logic [`TRSAC_NUM_SW-1:0] sw_rise;
    logic [`TRSAC_NUM_SW-1:0] sw_fall;

    assign sw_set[`TRSAC_SW_STOP] = lvl.stop_sw_stop;
    assign sw_clr[`TRSAC_SW_STOP] = lvl.stop_sw_normal;
    assign sw_set[`TRSAC_SW_STEP] = lvl.step_sw_press;
    assign sw_clr[`TRSAC_SW_STEP] = lvl.step_sw_rest;
    assign sw_set[`TRSAC_SW_SREAD] = lvl.sread_sw_press;
    assign sw_clr[`TRSAC_SW_SREAD] = lvl.sread_sw_rest;

    genvar gi;
    generate
        for (gi = 0; gi < `TRSAC_NUM_SW; gi = gi + 1) begin : g_sw
            logic sw_next;

            assign sw_next = (sw_set[gi] && !sw_clr[gi]) ? 1'b1 :
                             (sw_clr[gi] && !sw_set[gi]) ? 1'b0 : sw_reg[gi];

            always_ff @(posedge MCLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    sw_reg[gi] <= `TRSAC_BIT_RST;
                    sw_d_reg[gi] <= `TRSAC_BIT_RST;
                end else begin
                    sw_reg[gi] <= sw_next;
                    sw_d_reg[gi] <= sw_reg[gi];
                end
            end

            assign sw_rise[gi] = sw_reg[gi] & ~sw_d_reg[gi];
            assign sw_fall[gi] = ~sw_reg[gi] & sw_d_reg[gi];
        end
    endgenerate

    logic stop_on;
    logic stop_release;
    logic step_press;
    logic sread_press;
    logic sread_release;

    assign stop_on = sw_reg[`TRSAC_SW_STOP];
    assign stop_release = sw_fall[`TRSAC_SW_STOP];
    assign step_press = sw_rise[`TRSAC_SW_STEP];
    assign sread_press = sw_rise[`TRSAC_SW_SREAD];
    assign sread_release = sw_fall[`TRSAC_SW_SREAD];

    // ------------------------------------------------------------
    // Stop, step-read and manual step gating
    // ------------------------------------------------------------

    logic reader_stop;
    logic manual_ok;
    logic man_step;
    logic seq_step;
    logic sread_pulse;
    logic sread_reg;
    logic sread_next;

    assign reader_stop = stop_on & lvl.on_line;

    assign manual_ok = ~(~stop_on & lvl.on_line);

    assign man_step = step_press & manual_ok;

    assign seq_step = rise.seq_step & ~reader_stop;

    assign sread_pulse = sread_press & reader_stop & ~sread_reg;
    assign sread_next = sread_pulse ? 1'b1 :
                        (sread_release | ~reader_stop) ? 1'b0 : sread_reg;

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sread_reg <= `TRSAC_BIT_RST;
        end else begin
            sread_reg <= sread_next;
        end
    end

    // ------------------------------------------------------------
    // Restart tracking toward the verifier
    // ------------------------------------------------------------

    trsac_pkg::trsac_restart_t rst_state_reg;
    trsac_pkg::trsac_restart_t rst_state_next;
    logic restart_pulse;

    always_comb begin
        rst_state_next = rst_state_reg;
        restart_pulse = 1'b0;
        case (rst_state_reg)
            trsac_pkg::TRSAC_RUN: begin
                if (reader_stop) begin
                    rst_state_next = trsac_pkg::TRSAC_HELD;
                end
            end
            trsac_pkg::TRSAC_HELD: begin
                if (reader_stop && (man_step || sread_pulse)) begin
                    rst_state_next = trsac_pkg::TRSAC_STEPPED;
                end else if (!reader_stop) begin
                    rst_state_next = trsac_pkg::TRSAC_RUN;
                end
            end
            trsac_pkg::TRSAC_STEPPED: begin
                if (stop_release && lvl.on_line) begin
                    restart_pulse = 1'b1;
                    rst_state_next = trsac_pkg::TRSAC_RUN;
                end else if (!lvl.on_line) begin
                    rst_state_next = trsac_pkg::TRSAC_RUN;
                end
            end
            default: begin
                rst_state_next = trsac_pkg::TRSAC_RUN;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_state_reg <= trsac_pkg::TRSAC_RUN;
        end else begin
            rst_state_reg <= rst_state_next;
        end
    end

    // ------------------------------------------------------------
    // Alarm latches and header delete mode
    // ------------------------------------------------------------

    logic ver_set;
    logic feed_set;
    logic ver_next;
    logic feed_next;
    logic del_set;
    logic del_clr;
    logic del_next;
    logic ver_reg;
    logic feed_reg;
    logic del_reg;

    assign ver_set = lvl.verify_err & lvl.on_line;
    assign feed_set = lvl.feed_err & lvl.on_line;

    assign ver_next = ver_set | (ver_reg & ~rise.ver_rst_sw);
    assign feed_next = feed_set | (feed_reg & ~rise.feed_rst_sw);

    assign del_set = rise.hdr_del_sw & ~lvl.on_line;

    assign del_clr = fall.hdr_done & lvl.on_line;
    assign del_next = del_set | (del_reg & ~del_clr);

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ver_reg <= `TRSAC_BIT_RST;
            feed_reg <= `TRSAC_BIT_RST;
            del_reg <= `TRSAC_BIT_RST;
        end else begin
            ver_reg <= ver_next;
            feed_reg <= feed_next;
            del_reg <= del_next;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------

    trsac_pkg::trsac_out_t out_next;
    trsac_pkg::trsac_out_t out_reg;

    always_comb begin
        out_next = trsac_pkg::trsac_out_t'(`TRSAC_OUT_RST);
        out_next.reader_stop = reader_stop;
        out_next.stop_lamp = stop_on;
        out_next.step_read_pulse = sread_pulse;
        out_next.reader_step = man_step | seq_step | sread_pulse;
        out_next.verify_restart = restart_pulse;
        out_next.ver_lamp = ver_next;
        out_next.feed_lamp = feed_next;
        out_next.alarm = ver_next | feed_next;
        out_next.online_lamp = lvl.on_line;
        out_next.hdr_del_mode = del_next;
    end

    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            out_reg <= trsac_pkg::trsac_out_t'(`TRSAC_OUT_RST);
        end else begin
            out_reg <= out_next;
        end
    end

    assign READER_STOP = out_reg.reader_stop;
    assign STOP_LAMP = out_reg.stop_lamp;
    assign STEP_READ_PULSE = out_reg.step_read_pulse;
    assign READER_STEP = out_reg.reader_step;
    assign VERIFY_RESTART = out_reg.verify_restart;
    assign VER_LAMP = out_reg.ver_lamp;
    assign FEED_LAMP = out_reg.feed_lamp;
    assign ALARM = out_reg.alarm;
    assign ONLINE_LAMP = out_reg.online_lamp;
    assign HDR_DEL_MODE = out_reg.hdr_del_mode;

endmodule // trsac_top

// >>> trsac_checker.sv
// Port checker for the tape reader step and alarm control.
// Assumes it is bound to trsac_top and sees only its ports.
`timescale 1ns/100ps
module trsac_checker (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic ON_LINE,
    input wire logic SEQ_STEP,
    input wire logic FEED_ERR,
    input wire logic FEED_RST_SW,
    input wire logic STOP_SW_STOP,
    input wire logic STOP_SW_NORMAL,
    input wire logic READER_STOP,
    input wire logic STOP_LAMP,
    input wire logic STEP_READ_PULSE,
    input wire logic READER_STEP,
    input wire logic VERIFY_RESTART,
    input wire logic VER_LAMP,
    input wire logic FEED_LAMP,
    input wire logic ALARM,
    input wire logic HDR_DEL_MODE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);
    // On-line history covers the input pipeline depth.
    logic [5:0] on_hist;
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N)
            on_hist <= 6'h00;
        else
            on_hist <= {on_hist[4:0], ON_LINE};
    end
    sequence s_quiet_feed;
        !FEED_ERR[*4] ##1 $rose(FEED_RST_SW);
    endsequence
    sequence s_normal_idle;
        (ON_LINE && STOP_SW_NORMAL && !STOP_SW_STOP && !SEQ_STEP)[*8];
    endsequence
    property p_alarm_or; 1'b1 |-> ALARM == (VER_LAMP || FEED_LAMP); endproperty
    property p_err_online; $rose(VER_LAMP) || $rose(FEED_LAMP) |-> |on_hist; endproperty
    property p_feed_clear; s_quiet_feed ##1 (FEED_RST_SW && !FEED_ERR)[*5] |-> !FEED_LAMP; endproperty
    property p_stop; READER_STOP |-> STOP_LAMP && |on_hist; endproperty
    property p_hold; s_normal_idle |-> !READER_STEP; endproperty
    property p_sread; STEP_READ_PULSE |-> READER_STEP ##1 !STEP_READ_PULSE; endproperty
    property p_restart; VERIFY_RESTART |-> !READER_STOP ##1 !VERIFY_RESTART; endproperty
    property p_del_clr; $fell(HDR_DEL_MODE) |-> |on_hist; endproperty
    property p_del_set; $rose(HDR_DEL_MODE) |-> !(&on_hist); endproperty
    a_alarm_or: assert property (p_alarm_or) else $error("alarm not the or of lamps");
    a_err_online: assert property (p_err_online) else $error("alarm set off-line");
    a_feed_clear: assert property (p_feed_clear) else $error("feed lamp not cleared");
    a_stop: assert property (p_stop) else $error("reader stop without cause");
    a_hold: assert property (p_hold) else $error("step while on-line and normal");
    a_sread: assert property (p_sread) else $error("step-read pulse wrong");
    a_restart: assert property (p_restart) else $error("restart pulse wrong");
    a_del_clr: assert property (p_del_clr) else $error("delete cleared off-line");
    a_del_set: assert property (p_del_set) else $error("delete set on-line");
endmodule // trsac_checker
bind trsac_top trsac_checker u_chk (.MCLK, .RESET_N, .ON_LINE, .SEQ_STEP, .FEED_ERR, .FEED_RST_SW,
    .STOP_SW_STOP, .STOP_SW_NORMAL, .READER_STOP, .STOP_LAMP, .STEP_READ_PULSE, .READER_STEP,
    .VERIFY_RESTART, .VER_LAMP, .FEED_LAMP, .ALARM, .HDR_DEL_MODE);

// >>> trsac_far_model.sv
// Sequence control step source and reader driver step counter.
// Assumes the bench starts and stops it with run.
`timescale 1ns/100ps
module trsac_far_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic del_mode,
    input wire logic rd_step,
    output logic seq_step,
    output logic hdr_done,
    output logic [7:0] rd_cnt
);
    logic [1:0] ph_reg;
    logic [1:0] hdr_reg;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ph_reg <= 2'h0;
            hdr_reg <= 2'h0;
            rd_cnt <= 8'h00;
        end else begin
            ph_reg <= run ? ph_reg + 2'h1 : 2'h0;
            if (del_mode && ph_reg == 2'h3)
                hdr_reg <= hdr_reg + 2'h1;
            if (rd_step)
                rd_cnt <= rd_cnt + 8'h01;
        end
    end
    assign seq_step = run && !del_mode && ph_reg[1];
    assign hdr_done = hdr_reg[1];
endmodule // trsac_far_model

// >>> tb_tape_reader_step_alarm_control.sv
// Self-checking bench for the tape reader step and alarm control.
// Assumes trsac_top, trsac_far_model and the bound checker.
`timescale 1ns/100ps
module tb_tape_reader_step_alarm_control;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic run = 1'b0;
    logic seq_step, hdr_done, seq_q;
    logic [7:0] rd_cnt;
    trsac_pkg::trsac_in_t in_s = 14'h00a8;
    trsac_pkg::trsac_out_t out_s;
    int fails = 0, n_checks = 0, n_sr = 0, n_vr = 0, n_seq = 0, cyc_n = 0;
    trsac_top u_dut (.MCLK(mclk), .RESET_N(reset_n), .ON_LINE(in_s.on_line), .HDR_DONE(hdr_done),
        .SEQ_STEP(seq_step), .VERIFY_ERR(in_s.verify_err), .FEED_ERR(in_s.feed_err),
        .STOP_SW_STOP(in_s.stop_sw_stop), .STOP_SW_NORMAL(in_s.stop_sw_normal),
        .STEP_SW_PRESS(in_s.step_sw_press), .STEP_SW_REST(in_s.step_sw_rest),
        .SREAD_SW_PRESS(in_s.sread_sw_press), .SREAD_SW_REST(in_s.sread_sw_rest),
        .HDR_DEL_SW(in_s.hdr_del_sw), .VER_RST_SW(in_s.ver_rst_sw), .FEED_RST_SW(in_s.feed_rst_sw),
        .READER_STOP(out_s.reader_stop), .STOP_LAMP(out_s.stop_lamp),
        .STEP_READ_PULSE(out_s.step_read_pulse), .READER_STEP(out_s.reader_step),
        .VERIFY_RESTART(out_s.verify_restart), .VER_LAMP(out_s.ver_lamp), .FEED_LAMP(out_s.feed_lamp),
        .ALARM(out_s.alarm), .ONLINE_LAMP(out_s.online_lamp), .HDR_DEL_MODE(out_s.hdr_del_mode));
    trsac_far_model u_far (.mclk(mclk), .reset_n(reset_n), .run(run), .del_mode(out_s.hdr_del_mode),
        .rd_step(out_s.reader_step), .seq_step(seq_step), .hdr_done(hdr_done), .rd_cnt(rd_cnt));
    always #50 mclk = ~mclk;
    // Pulses are counted on the falling edge, where outputs have settled.
    always @(negedge mclk) begin
        n_sr += out_s.step_read_pulse;
        n_vr += out_s.verify_restart;
        n_seq += (seq_step && !seq_q);
        seq_q = seq_step;
        cyc_n++;
        if (cyc_n == 3000) begin
            fails++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] v, input logic [7:0] e);
        n_checks++;
        if (v !== e) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, v, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #10;
    endtask
    task automatic set_sw(input bit rd, input logic [1:0] v);
        if (rd)
            {in_s.sread_sw_press, in_s.sread_sw_rest} = v;
        else
            {in_s.step_sw_press, in_s.step_sw_rest} = v;
    endtask
    // Contact bounce in mid-press must still give one event.
    task automatic press(input bit rd);
        set_sw(rd, 2'h2);
        cyc(3);
        set_sw(rd, 2'h0);
        cyc(2);
        set_sw(rd, 2'h2);
        cyc(4);
        set_sw(rd, 2'h1);
        cyc(8);
    endtask
    task automatic del_press();
        in_s.hdr_del_sw = 1'b1;
        cyc(4);
        in_s.hdr_del_sw = 1'b0;
        cyc(6);
    endtask
    task automatic seq_burst();
        logic [7:0] c;
        int q;
        run = 1'b0;
        cyc(10);
        c = rd_cnt;
        q = n_seq;
        run = 1'b1;
        cyc(20 + $urandom_range(20, 0));
        run = 1'b0;
        cyc(10);
        chk(rd_cnt - c, q[7:0] - n_seq[7:0] + 8'h00 - 8'h00 + (n_seq[7:0] - q[7:0]) * 8'h02);
    endtask
    initial begin
        logic [7:0] c0;
        int k;
        void'($urandom(80464));
        repeat (6) @(posedge mclk);
        #10;
        reset_n = 1'b1;
        cyc(2);
        in_s.verify_err = 1'b1;
        cyc(8);
        chk(out_s.ver_lamp, 8'h00);
        in_s.on_line = 1'b1;
        cyc(8);
        chk({out_s.ver_lamp, out_s.alarm, out_s.online_lamp}, 8'h07);
        in_s.verify_err = 1'b0;
        in_s.feed_err = 1'b1;
        cyc(8);
        in_s.feed_err = 1'b0;
        in_s.ver_rst_sw = 1'b1;
        cyc(8);
        chk({out_s.ver_lamp, out_s.feed_lamp, out_s.alarm}, 8'h03);
        in_s.feed_rst_sw = 1'b1;
        cyc(8);
        chk(out_s.alarm, 8'h00);
        $display("test alarms done");
        del_press();
        chk(out_s.hdr_del_mode, 8'h00);
        in_s.on_line = 1'b0;
        cyc(6);
        chk(out_s.online_lamp, 8'h00);
        del_press();
        chk(out_s.hdr_del_mode, 8'h01);
        in_s.on_line = 1'b1;
        run = 1'b1;
        for (k = 0; k < 100 && out_s.hdr_del_mode !== 1'b0; k++)
            cyc(1);
        chk(out_s.hdr_del_mode, 8'h00);
        seq_burst();
        $display("test delete done");
        run = 1'b1;
        in_s.stop_sw_stop = 1'b1;
        in_s.stop_sw_normal = 1'b0;
        cyc(8);
        chk({out_s.reader_stop, out_s.stop_lamp}, 8'h03);
        c0 = rd_cnt;
        cyc(20);
        chk(rd_cnt, c0);
        press(1'b1);
        chk(rd_cnt, c0 + 8'h01);
        chk(n_sr[7:0], 8'h01);
        press(1'b0);
        chk(rd_cnt, c0 + 8'h02);
        run = 1'b0;
        in_s.stop_sw_stop = 1'b0;
        in_s.stop_sw_normal = 1'b1;
        cyc(8);
        chk(out_s.reader_stop, 8'h00);
        chk(n_vr[7:0], 8'h01);
        seq_burst();
        $display("test stop done");
        c0 = rd_cnt;
        press(1'b0);
        chk(rd_cnt, c0);
        in_s.on_line = 1'b0;
        press(1'b1);
        chk(n_sr[7:0], 8'h01);
        k = $urandom_range(4, 1);
        repeat (k) press(1'b0);
        chk(rd_cnt, c0 + k[7:0]);
        $display("test manual done");
        // Going off-line after an on-line manual step cancels the restart pulse.
        in_s.on_line = 1'b1;
        in_s.stop_sw_stop = 1'b1;
        in_s.stop_sw_normal = 1'b0;
        cyc(8);
        c0 = rd_cnt;
        press(1'b0);
        chk(rd_cnt, c0 + 8'h01);
        in_s.on_line = 1'b0;
        cyc(6);
        in_s.stop_sw_stop = 1'b0;
        in_s.stop_sw_normal = 1'b1;
        cyc(8);
        chk(n_vr[7:0], 8'h01);
        $display("test cancel done");
        test_done();
    end
endmodule // tb_tape_reader_step_alarm_control
